/* design/cit_pkg.sv */
package cit_pkg;

    // longest instruction, in clocks
    localparam logic [3:0] MAX_CYCLES = 4'h8;
    localparam logic [3:0] MUL_CYCLES = 4'h4;
    localparam logic [3:0] XFER_CYCLES = 4'h3;
    localparam logic [3:0] TWO_CYCLES = 4'h2;
    localparam logic [3:0] ONE_CYCLE = 4'h1;
    localparam logic [3:0] FIRST_INDEX = 4'h0;
    localparam logic [1:0] ONE_BYTE = 2'h1;
    localparam logic [1:0] NO_BYTES = 2'h0;
    localparam logic [7:0] CLEAR_BYTE = 8'h00;

    // opcodes the checks single out
    localparam logic [7:0] OP_MUL = 8'hA4;
    localparam logic [7:0] OP_DIV = 8'h84;

    // decoded length and not-taken clock count of one opcode
    typedef struct packed {
        logic [1:0] len;
        logic [3:0] cyc;
        logic cond;
    } cit_time_s;

    // instruction currently in the sequencer
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] operand1;
        logic [7:0] operand2;
        logic [1:0] len;
    } cit_instr_s;

    typedef enum logic [2:0] {
        CIT_OPCODE = 3'b001,
        CIT_OPERAND = 3'b010,
        CIT_HOLD = 3'b100
    } cit_state_e;

endpackage : cit_pkg

/* design/cit_decode.sv */
`timescale 1ns/1ps
module cit_decode (
    input wire logic [7:0] opcode,
    output cit_pkg::cit_time_s timing
);

    function automatic cit_pkg::cit_time_s mk(input logic [1:0] l, input logic [3:0] c,
                                              input logic b);
        cit_pkg::cit_time_s r;
        r.len = l;
        r.cyc = c;
        r.cond = b;
        return r;
    endfunction : mk

    function automatic cit_pkg::cit_time_s lookup(input logic [7:0] op);
        logic [3:0] hi;
        logic [3:0] lo;
        cit_pkg::cit_time_s r;
        hi = op[7:4];
        lo = op[3:0];
        r = mk(2'h1, 4'h1, 1'b0);
        if (lo[3])
        begin
            // working_register_operand column
            case (hi)
                4'h7, 4'h8, 4'hA: r = mk(2'h2, 4'h2, 1'b0);
                4'hB: r = mk(2'h3, 4'h3, 1'b1);
                4'hD: r = mk(2'h2, 4'h2, 1'b1);
                default: r = mk(2'h1, 4'h1, 1'b0);
            endcase
        end
        else if (lo[3:1] == 3'b011)
        begin
            // register_indirect_operand column
            case (hi)
                4'h7, 4'h8, 4'hA: r = mk(2'h2, 4'h2, 1'b0);
                4'hB: r = mk(2'h3, 4'h4, 1'b1);
                default: r = mk(2'h1, 4'h2, 1'b0);
            endcase
        end
        else
        begin
            case (lo)
                4'h5:
                    case (hi)
                        4'h7, 4'h8: r = mk(2'h3, 4'h3, 1'b0);
                        4'hA: r = mk(2'h1, 4'h1, 1'b0);
                        4'hB, 4'hD: r = mk(2'h3, 4'h3, 1'b1);
                        default: r = mk(2'h2, 4'h2, 1'b0);
                    endcase
                4'h4:
                    case (hi)
                        4'h0, 4'h1, 4'hC, 4'hD, 4'hE, 4'hF: r = mk(2'h1, 4'h1, 1'b0);
                        4'h8: r = mk(2'h1, 4'h8, 1'b0);
                        4'hA: r = mk(2'h1, 4'h4, 1'b0);
                        4'hB: r = mk(2'h3, 4'h3, 1'b1);
                        default: r = mk(2'h2, 4'h2, 1'b0);
                    endcase
                4'h1: r = mk(2'h2, 4'h3, 1'b0);
                4'h0:
                    case (hi)
                        4'h0: r = mk(2'h1, 4'h1, 1'b0);
                        4'h1, 4'h2, 4'h3: r = mk(2'h3, 4'h3, 1'b1);
                        4'h4, 4'h5, 4'h6, 4'h7: r = mk(2'h2, 4'h2, 1'b1);
                        4'h8: r = mk(2'h2, 4'h3, 1'b0);
                        4'h9: r = mk(2'h3, 4'h3, 1'b0);
                        4'hE, 4'hF: r = mk(2'h1, 4'h3, 1'b0);
                        default: r = mk(2'h2, 4'h2, 1'b0);
                    endcase
                4'h2:
                    case (hi)
                        4'h0, 4'h1: r = mk(2'h3, 4'h4, 1'b0);
                        4'h2, 4'h3: r = mk(2'h1, 4'h5, 1'b0);
                        4'h4, 4'h5, 4'h6: r = mk(2'h2, 4'h2, 1'b0);
                        4'hE, 4'hF: r = mk(2'h1, 4'h3, 1'b0);
                        default: r = mk(2'h2, 4'h2, 1'b0);
                    endcase
                4'h3:
                    case (hi)
                        4'h4, 4'h5, 4'h6: r = mk(2'h3, 4'h3, 1'b0);
                        4'h7, 4'h8, 4'h9, 4'hE, 4'hF: r = mk(2'h1, 4'h3, 1'b0);
                        default: r = mk(2'h1, 4'h1, 1'b0);
                    endcase
                default: r = mk(2'h1, 4'h1, 1'b0);
            endcase
        end
        return r;
    endfunction : lookup

    assign timing = lookup(opcode);

endmodule : cit_decode

/* design/cit_timing_core.sv */
`timescale 1ns/1ps
module cit_timing_core (
    input wire logic mclk,
    input wire logic reset,
    input wire logic code_valid,
    input wire logic [7:0] code_byte,
    output logic code_ready,
    input wire logic branch_taken,
    output logic busy,
    output cit_pkg::cit_instr_s cur_instr,
    output logic [3:0] cycle_index,
    output logic retire,
    output logic [3:0] retire_cycles,
    output logic retire_taken
);

    ////////////////////////////////////////////////////////////////////////////
    // decode and sequencing state

    cit_pkg::cit_time_s dec;
    cit_pkg::cit_time_s cur_t;
    cit_pkg::cit_time_s act_t;
    cit_pkg::cit_state_e state;
    cit_pkg::cit_state_e next_state;
    logic [3:0] idx;
    logic [1:0] bytes_left;
    logic accept;
    logic advance;
    logic base_last;
    logic extend;
    logic last;

    cit_decode u_decode (
        .opcode(code_byte),
        .timing(dec)
    );

    // opcode and operand bytes are pulled one per clock; the rest of the time the fetch stalls
    assign code_ready = (state == cit_pkg::CIT_OPCODE) || (state == cit_pkg::CIT_OPERAND);
    assign accept = code_valid && code_ready;
    assign busy = (state != cit_pkg::CIT_OPCODE);
    assign act_t = (state == cit_pkg::CIT_OPCODE) ? dec : cur_t;

    always_comb
    begin
        case (state)
            cit_pkg::CIT_OPCODE: advance = accept;
            cit_pkg::CIT_OPERAND: advance = code_valid;
            cit_pkg::CIT_HOLD: advance = 1'b1;
            default: advance = 1'b0;
        endcase
    end

    // branch outcome is only looked at in the last not-taken clock
    assign base_last = (idx == 4'(act_t.cyc - cit_pkg::ONE_CYCLE));
    assign extend = act_t.cond && branch_taken;
    assign last = advance && ((base_last && !extend) || (idx == act_t.cyc));

    always_comb
    begin
        next_state = state;
        case (state)
            cit_pkg::CIT_OPCODE:
            begin
                if (accept && !last)
                begin
                    next_state = (dec.len > cit_pkg::ONE_BYTE) ? cit_pkg::CIT_OPERAND
                                                                : cit_pkg::CIT_HOLD;
                end
            end
            cit_pkg::CIT_OPERAND:
            begin
                if (code_valid)
                begin
                    if (last)
                    begin
                        next_state = cit_pkg::CIT_OPCODE;
                    end
                    else if (bytes_left == cit_pkg::ONE_BYTE)
                    begin
                        next_state = cit_pkg::CIT_HOLD;
                    end
                end
            end
            cit_pkg::CIT_HOLD:
            begin
                if (last)
                begin
                    next_state = cit_pkg::CIT_OPCODE;
                end
            end
            default: next_state = cit_pkg::CIT_OPCODE;
        endcase
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            state <= cit_pkg::CIT_OPCODE;
        end
        else
        begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock and byte counting

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            idx <= cit_pkg::FIRST_INDEX;
        end
        else if (last)
        begin
            idx <= cit_pkg::FIRST_INDEX;
        end
        else if (advance)
        begin
            idx <= 4'(idx + cit_pkg::ONE_CYCLE);
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            bytes_left <= cit_pkg::NO_BYTES;
        end
        else if (accept && state == cit_pkg::CIT_OPCODE)
        begin
            bytes_left <= 2'(dec.len - cit_pkg::ONE_BYTE);
        end
        else if (accept)
        begin
            bytes_left <= 2'(bytes_left - cit_pkg::ONE_BYTE);
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            cur_t <= '0;
        end
        else if (accept && state == cit_pkg::CIT_OPCODE)
        begin
            cur_t <= dec;
        end
    end

    assign cycle_index = idx;

    ////////////////////////////////////////////////////////////////////////////
    // instruction bytes as seen by the datapath

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            cur_instr <= '0;
        end
        else if (accept && state == cit_pkg::CIT_OPCODE)
        begin
            cur_instr.opcode <= code_byte;
            cur_instr.operand1 <= cit_pkg::CLEAR_BYTE;
            cur_instr.operand2 <= cit_pkg::CLEAR_BYTE;
            cur_instr.len <= dec.len;
        end
        else if (accept && idx == cit_pkg::ONE_CYCLE)
        begin
            cur_instr.operand1 <= code_byte;
        end
        else if (accept)
        begin
            cur_instr.operand2 <= code_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // completion report, one clock after the final clock of an instruction

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            retire <= 1'b0;
            retire_cycles <= cit_pkg::FIRST_INDEX;
            retire_taken <= 1'b0;
        end
        else
        begin
            retire <= last;
            if (last)
            begin
                retire_cycles <= 4'(idx + cit_pkg::ONE_CYCLE);
                retire_taken <= (idx == act_t.cyc);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    function automatic logic is_single(input logic [7:0] op);
        logic [3:0] hi;
        logic hit;
        hi = op[7:4];
        hit = 1'b0;
        if (op[3] && !(hi inside {4'h7, 4'h8, 4'hA, 4'hB, 4'hD}))
        begin
            hit = 1'b1;
        end
        if (op inside {8'h04, 8'h14, 8'hC4, 8'hD4, 8'hE4, 8'hF4, 8'h03, 8'h13, 8'h23,
                       8'h33, 8'hA3, 8'hB3, 8'hC3, 8'hD3})
        begin
            hit = 1'b1;
        end
        return hit;
    endfunction : is_single

    function automatic logic is_indirect(input logic [7:0] op);
        return (op[3:1] == 3'b011) && !(op[7:4] inside {4'h7, 4'h8, 4'hA, 4'hB});
    endfunction : is_indirect

    function automatic logic is_three_clock(input logic [7:0] op);
        return op inside {8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3, 8'h83, 8'h93};
    endfunction : is_three_clock

    function automatic logic is_byte_paced(input logic [7:0] op);
        logic [3:0] hi;
        logic [3:0] lo;
        logic hit;
        hi = op[7:4];
        lo = op[3:0];
        hit = 1'b0;
        if (lo == 4'h5 && !(hi inside {4'hA, 4'hB, 4'hD}))
        begin
            hit = 1'b1;
        end
        if (lo == 4'h4 && hi inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9})
        begin
            hit = 1'b1;
        end
        if ((lo[3] || lo[3:1] == 3'b011) && hi inside {4'h7, 4'h8, 4'hA})
        begin
            hit = 1'b1;
        end
        if (op inside {8'h42, 8'h52, 8'h62, 8'h43, 8'h53, 8'h63, 8'h72, 8'h82, 8'h92,
                       8'hA2, 8'hB2, 8'hC2, 8'hD2, 8'hA0, 8'hB0, 8'hC0, 8'hD0, 8'h90})
        begin
            hit = 1'b1;
        end
        return hit;
    endfunction : is_byte_paced

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    sequence s_start(logic hit);
        accept && state == cit_pkg::CIT_OPCODE && hit;
    endsequence

    sequence s_quiet_then_retire(logic [3:0] n);
        !retire [*1] ##1 (retire && retire_cycles == n);
    endsequence

    chk_div_eight: assert property (
        s_start(code_byte == cit_pkg::OP_DIV) |=> !retire [*7] ##1
            (retire && retire_cycles == cit_pkg::MAX_CYCLES))
        else $error("divide did not take eight clocks");

    chk_mul_four: assert property (
        s_start(code_byte == cit_pkg::OP_MUL) |=> !retire [*3] ##1
            (retire && retire_cycles == cit_pkg::MUL_CYCLES))
        else $error("multiply did not take four clocks");

    chk_xfer_three: assert property (
        s_start(is_three_clock(code_byte)) |=> !retire [*2] ##1
            (retire && retire_cycles == cit_pkg::XFER_CYCLES))
        else $error("external or code byte move not three clocks");

    chk_single_clock: assert property (
        s_start(is_single(code_byte)) |=> retire && retire_cycles == cit_pkg::ONE_CYCLE
            && !busy)
        else $error("single clock instruction took longer");

    chk_indirect_two: assert property (
        s_start(is_indirect(code_byte)) |=> s_quiet_then_retire(cit_pkg::TWO_CYCLES))
        else $error("indirect instruction not two clocks");

    chk_bytes_equal_clocks: assert property (
        retire && is_byte_paced(cur_instr.opcode) |->
            retire_cycles == 4'(cur_instr.len) && cur_instr.len != cit_pkg::ONE_BYTE)
        else $error("clock count differs from byte count");

    chk_branch_penalty: assert property (
        retire |-> retire_cycles == 4'(cur_t.cyc + {3'b000, retire_taken})
            && (cur_t.cond || !retire_taken))
        else $error("branch clock count wrong");

    chk_hold_no_fetch: assert property (
        state == cit_pkg::CIT_HOLD |-> !code_ready ##1
            (state == cit_pkg::CIT_HOLD || $past(last)))
        else $error("fetch during hold or hold left early");

    chk_stall_freezes: assert property (
        state == cit_pkg::CIT_OPERAND && !code_valid |=> $stable(idx) && !retire)
        else $error("clock counted without an operand byte");

    chk_clock_bound: assert property (
        busy |-> idx < cit_pkg::MAX_CYCLES)
        else $error("instruction ran past the longest count");

endmodule : cit_timing_core

/* test/cit_prog_mem.sv */
`timescale 1ns/1ps
module cit_prog_mem (
    input wire logic mclk,
    input wire logic reset,
    input wire logic run,
    input wire logic stall,
    input wire logic [7:0] prog_len,
    input wire logic code_ready,
    output logic code_valid,
    output logic [7:0] code_byte
);
    logic [7:0] mem [256];
    logic [7:0] pc;
    logic [7:0] last_byte;

    assign code_valid = run && !stall && (pc < prog_len);
    // an idle fetch bus shows the inverse of the last byte, so a stale byte never passes
    assign code_byte = code_valid ? mem[pc] : ~last_byte;

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            pc <= 8'h00;
            last_byte <= 8'h00;
        end
        else if (!run)
            pc <= 8'h00;
        else if (code_valid && code_ready)
        begin
            pc <= pc + 8'h01;
            last_byte <= mem[pc];
        end
    end
endmodule : cit_prog_mem

/* test/tb_cit_timing_core.sv */
`timescale 1ns/1ps
module tb_cit_timing_core;
    typedef logic [15:0] cit_tb_list_t [$];
    logic mclk;
    logic reset;
    logic code_valid;
    logic [7:0] code_byte;
    logic code_ready;
    logic branch_taken;
    logic busy;
    cit_pkg::cit_instr_s cur_instr;
    logic [3:0] cycle_index;
    logic retire;
    logic [3:0] retire_cycles;
    logic retire_taken;
    logic run;
    logic stall;
    logic [7:0] prog_len;
    int miscompares = 0;
    int samples_checked = 0;

    cit_timing_core i_cit_timing_core (.mclk(mclk), .reset(reset), .code_valid(code_valid),
        .code_byte(code_byte), .code_ready(code_ready), .branch_taken(branch_taken),
        .busy(busy), .cur_instr(cur_instr), .cycle_index(cycle_index), .retire(retire),
        .retire_cycles(retire_cycles), .retire_taken(retire_taken));
    cit_prog_mem i_cit_prog_mem (.mclk(mclk), .reset(reset), .run(run), .stall(stall),
        .prog_len(prog_len), .code_ready(code_ready), .code_valid(code_valid),
        .code_byte(code_byte));

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] want);
        samples_checked++;
        if (got !== want)
        begin
            miscompares++;
            $display("mismatch at %0t: got 0x%0h expected 0x%0h", $time, got, want);
        end
    endtask : cmp_val

    ////////////////////////////////////////////////////////////////////////////////
    // entries are {opcode, bytes, not-taken clocks}; a leading one-byte opcode lines up
    // the pipeline so every listed entry is timed retire to retire, back to back
    task automatic run_list(input cit_tb_list_t ops, input logic br, input logic cond,
                            input int sk);
        int a;
        int n;
        int holds;
        int busys;
        logic [3:0] end_idx;
        logic [7:0] base [$];
        logic [3:0] len;
        logic [3:0] want;
        logic [7:0] o1;
        logic [7:0] o2;
        @(posedge mclk);
        #1;
        i_cit_prog_mem.mem[0] = 8'h00;
        a = 1;
        foreach (ops[q])
        begin
            base.push_back(8'(a));
            i_cit_prog_mem.mem[a] = ops[q][15:8];
            for (int j = 1; j < 32'(ops[q][7:4]); j++)
                i_cit_prog_mem.mem[a + j] = 8'(a + j) ^ 8'hA5;
            a = a + 32'(ops[q][7:4]);
        end
        prog_len = 8'(a);
        branch_taken = br;
        run = 1'b1;
        n = 0;
        while (retire !== 1'b1 && n < 40)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        for (int i = 0; i < ops.size(); i++)
        begin
            len = ops[i][7:4];
            want = ops[i][3:0] + 4'(br & cond);
            o1 = (len > 4'h1) ? ((base[i] + 8'h01) ^ 8'hA5) : 8'h00;
            o2 = (len > 4'h2) ? ((base[i] + 8'h02) ^ 8'hA5) : 8'h00;
            n = 0;
            holds = 0;
            busys = 0;
            do
            begin
                stall = (i == sk) && (n == 1 || n == 2);
                holds += (code_ready === 1'b0) ? 1 : 0;
                busys += (busy === 1'b1) ? 1 : 0;
                end_idx = cycle_index;
                @(posedge mclk);
                #1;
                n++;
            end while (retire !== 1'b1 && n < 20);
            cmp_val(32'(n), 32'(want) + ((i == sk) ? 32'd2 : 32'd0));
            cmp_val(32'(holds), 32'(want) - 32'(len));
            cmp_val(32'(retire_cycles), 32'(want));
            cmp_val(32'(retire_taken), 32'(br & cond));
            cmp_val(32'(cur_instr), 32'({ops[i][15:8], o1, o2, len[1:0]}));
            cmp_val(32'(busys), 32'(want) - 32'h1 + ((i == sk) ? 32'h2 : 32'h0));
            cmp_val(32'(end_idx), 32'(want) - 32'h1);
        end
        run = 1'b0;
        stall = 1'b0;
        branch_taken = 1'b0;
    endtask : run_list

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_arith;
        // a taken flag on non-conditional opcodes must add nothing
        run_list('{16'h2811, 16'h3F11, 16'h9911, 16'h5811, 16'h4911, 16'h6A11}, 1'b1, 1'b0, -1);
        run_list('{16'h2522, 16'h2422, 16'h3522, 16'h3422, 16'h9522, 16'h9422, 16'h5522,
                   16'h4422}, 1'b0, 1'b0, -1);
        run_list('{16'h2612, 16'h3712, 16'h9612, 16'h5612, 16'h4712, 16'h6612}, 1'b0, 1'b0, -1);
        run_list('{16'h0612, 16'h1712, 16'h0522, 16'h1522}, 1'b0, 1'b0, -1);
        $display("test arith done");
    endtask : t_arith

    task automatic t_logic;
        run_list('{16'h5333, 16'h4333, 16'h6333}, 1'b0, 1'b0, -1);
        run_list('{16'h5222, 16'h4222, 16'h6222}, 1'b0, 1'b0, -1);
        $display("test logic done");
    endtask : t_logic

    task automatic t_accum;
        run_list('{16'hA311}, 1'b0, 1'b0, -1);
        run_list('{16'hE411, 16'hF411, 16'h2311, 16'h3311, 16'h0311, 16'h1311, 16'hC411,
                   16'hD411, 16'h0411, 16'h1411}, 1'b0, 1'b0, -1);
        $display("test accum done");
    endtask : t_accum

    task automatic t_transfer;
        run_list('{16'hE213, 16'hF213, 16'hE313, 16'hF313, 16'hE013, 16'hF013}, 1'b0,
                 1'b0, -1);
        // register and accumulator moves
        run_list('{16'hE522, 16'hF522, 16'h7422, 16'h7822, 16'hA822, 16'h8822, 16'h8622,
                   16'hE612, 16'hE811, 16'hF811}, 1'b0, 1'b0, -1);
        run_list('{16'h9313, 16'h8313}, 1'b0, 1'b0, -1);
        run_list('{16'h9033}, 1'b0, 1'b0, -1);
        // operand fetch of the second move stalls two clocks; its count must not grow
        run_list('{16'h8533, 16'h7533}, 1'b0, 1'b0, 1);
        run_list('{16'hF612, 16'hA622, 16'h7622}, 1'b0, 1'b0, -1);
        $display("test transfer done");
    endtask : t_transfer

    task automatic t_stack_xch;
        run_list('{16'hC022, 16'hD022}, 1'b0, 1'b0, -1);
        run_list('{16'hC811, 16'hC522, 16'hC612, 16'hD612}, 1'b0, 1'b0, -1);
        $display("test stack_xch done");
    endtask : t_stack_xch

    task automatic t_bool;
        run_list('{16'hC311, 16'hD311, 16'hB311, 16'hC222, 16'hD222, 16'hB222}, 1'b0, 1'b0, -1);
        run_list('{16'h8222}, 1'b0, 1'b0, -1);
        $display("test bool done");
    endtask : t_bool

    task automatic t_muldiv;
        run_list('{16'hA414, 16'h8418, 16'hA414}, 1'b0, 1'b0, -1);
        $display("test muldiv done");
    endtask : t_muldiv

    task automatic t_branch;
        cit_tb_list_t conds;
        conds = '{16'h4022, 16'h5022, 16'h6022, 16'h7022, 16'h2033, 16'h3033, 16'h1033,
                  16'hB433, 16'hB533, 16'hB833, 16'hB634, 16'hD533, 16'hD822};
        run_list(conds, 1'b0, 1'b1, -1);
        run_list(conds, 1'b1, 1'b1, -1);
        $display("test branch done");
    endtask : t_branch

    // reset in the middle of a divide must abandon it and clear all status
    task automatic t_reset_mid;
        @(posedge mclk);
        #1;
        i_cit_prog_mem.mem[0] = cit_pkg::OP_DIV;
        prog_len = 8'h01;
        run = 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        reset = 1'b1;
        @(posedge mclk);
        #1;
        cmp_val(32'(code_ready), 32'h1);
        cmp_val(32'(busy), 32'h0);
        cmp_val(32'(retire), 32'h0);
        cmp_val(32'({retire_cycles, retire_taken, cycle_index}), 32'h0);
        cmp_val(32'(cur_instr), 32'h0);
        run = 1'b0;
        @(posedge mclk);
        #1;
        reset = 1'b0;
        @(posedge mclk);
        #1;
        cmp_val(32'({code_ready, busy, retire, cycle_index}), 32'h40);
        $display("test reset_mid done");
    endtask : t_reset_mid

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        reset = 1'b1;
        run = 1'b0;
        stall = 1'b0;
        branch_taken = 1'b0;
        prog_len = 8'h00;
        repeat (16) @(posedge mclk);
        #1;
        reset = 1'b0;
        t_arith();
        t_logic();
        t_accum();
        t_transfer();
        t_stack_xch();
        t_bool();
        t_reset_mid();
        t_muldiv();
        t_branch();
        test_done();
    end

    // the whole sequence needs well under 2000 clocks
    initial
    begin
        #40000;
        miscompares++;
        $display("watchdog expired");
        test_done();
    end
endmodule : tb_cit_timing_core
